// [src/bstp_port.v]
`timescale 1ns/10ps
`include "bstp_defines.vh"
module bstp_port #(
  parameter IR_WIDTH = `BSTP_IR_WIDTH,
  parameter ID_WIDTH = `BSTP_ID_WIDTH,
  parameter [31:0] ID_VALUE = 32'h00000001 // arbitrary identity value
) (
  input wire CLOCK, // system clock 250 MHz
  input wire SYS_RST, // async reset, high
  input wire TCK, // test clock pin
  input wire TMS, // test mode select pin
  input wire TDI, // test data in pin
  input wire TRST_N, // test reset pin, low active
  output wire TDO_O, // test data out value
  output wire TDO_OE, // test data out enable
  output wire [IR_WIDTH-1:0] INSTR, // active instruction
  output wire TAP_RESET // port in reset state
);
  localparam [15:0] S_TLR = 16'h0001, S_RTI = 16'h0002, S_SDS = 16'h0004, S_CDR = 16'h0008;
  localparam [15:0] S_SDR = 16'h0010, S_E1D = 16'h0020, S_PDR = 16'h0040, S_E2D = 16'h0080;
  localparam [15:0] S_UDR = 16'h0100, S_SIS = 16'h0200, S_CIR = 16'h0400, S_SIR = 16'h0800;
  localparam [15:0] S_E1I = 16'h1000, S_PIR = 16'h2000, S_E2I = 16'h4000, S_UIR = 16'h8000;

  wire tck_s, tms_s, tdi_s, trst_n_s;
  bstp_sync u_tck (.clk(CLOCK), .rst(SYS_RST), .d_in(TCK), .q_out(tck_s));
  bstp_sync u_tms (.clk(CLOCK), .rst(SYS_RST), .d_in(TMS), .q_out(tms_s));
  bstp_sync u_tdi (.clk(CLOCK), .rst(SYS_RST), .d_in(TDI), .q_out(tdi_s));
  // asserted trst still acts at once below; sync only keeps it held cleanly
  bstp_sync u_trst (.clk(CLOCK), .rst(SYS_RST), .d_in(TRST_N), .q_out(trst_n_s));

  // reset when pin low (direct, asynchronous) or until synchronised release
  wire port_rst = SYS_RST | ~TRST_N | ~trst_n_s;

  reg tck_d_ff;
  always @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST)
      tck_d_ff <= 1'b0;
    else
      tck_d_ff <= tck_s;
  end
  wire tck_rise = tck_s & ~tck_d_ff;
  wire tck_fall = ~tck_s & tck_d_ff;

  reg [15:0] state_ff, nxt_state;
  reg [IR_WIDTH-1:0] ir_sh_ff, ir_ff;
  reg [ID_WIDTH-1:0] dr_sh_ff;
  reg tdo_ff, tdo_oe_ff;

  always @* begin
    case (state_ff)
      S_TLR: nxt_state = tms_s ? S_TLR : S_RTI;
      S_RTI: nxt_state = tms_s ? S_SDS : S_RTI;
      S_SDS: nxt_state = tms_s ? S_SIS : S_CDR;
      S_CDR: nxt_state = tms_s ? S_E1D : S_SDR;
      S_SDR: nxt_state = tms_s ? S_E1D : S_SDR;
      S_E1D: nxt_state = tms_s ? S_UDR : S_PDR;
      S_PDR: nxt_state = tms_s ? S_E2D : S_PDR;
      S_E2D: nxt_state = tms_s ? S_UDR : S_SDR;
      S_UDR: nxt_state = tms_s ? S_SDS : S_RTI;
      S_SIS: nxt_state = tms_s ? S_TLR : S_CIR;
      S_CIR: nxt_state = tms_s ? S_E1I : S_SIR;
      S_SIR: nxt_state = tms_s ? S_E1I : S_SIR;
      S_E1I: nxt_state = tms_s ? S_UIR : S_PIR;
      S_PIR: nxt_state = tms_s ? S_E2I : S_PIR;
      S_E2I: nxt_state = tms_s ? S_UIR : S_SIR;
      S_UIR: nxt_state = tms_s ? S_SDS : S_RTI;
      default: nxt_state = S_TLR;
    endcase
  end

  wire is_bypass = (ir_ff == `BSTP_OP_BYPASS);
  wire dr_len1 = is_bypass | (ir_ff != `BSTP_OP_IDCODE);

  // apart from reset, every flop only moves on a test clock edge, so a parked clock freezes all
  always @(posedge CLOCK or posedge port_rst) begin
    if (port_rst) begin
      state_ff <= S_TLR;
      ir_sh_ff <= {IR_WIDTH{1'b0}};
      ir_ff <= `BSTP_IR_RESET;
      dr_sh_ff <= {ID_WIDTH{1'b0}};
      tdo_ff <= 1'b0;
      tdo_oe_ff <= 1'b0;
    end else begin
      if (tck_rise) begin
        state_ff <= nxt_state;
        case (state_ff)
          S_TLR: ir_ff <= `BSTP_IR_RESET;
          S_CIR: ir_sh_ff <= `BSTP_IR_CAPTURE;
          S_SIR: ir_sh_ff <= {tdi_s, ir_sh_ff[IR_WIDTH-1:1]};
          S_UIR: ir_ff <= ir_sh_ff;
          S_CDR: dr_sh_ff <= dr_len1 ? {ID_WIDTH{1'b0}} : ID_VALUE[ID_WIDTH-1:0];
          S_SDR: begin
            if (dr_len1)
              dr_sh_ff <= {{(ID_WIDTH-1){1'b0}}, tdi_s};
            else
              dr_sh_ff <= {tdi_s, dr_sh_ff[ID_WIDTH-1:1]};
          end
          default: ir_ff <= ir_ff;
        endcase
      end
      if (tck_fall) begin
        // output bit and enable update only here, half a period before sampling
        tdo_ff <= (state_ff == S_SIR) ? ir_sh_ff[0] : dr_sh_ff[0];
        tdo_oe_ff <= (state_ff == S_SIR) | (state_ff == S_SDR);
      end
    end
  end

  assign TDO_O = tdo_ff;
  assign TDO_OE = tdo_oe_ff;
  assign INSTR = ir_ff;
  assign TAP_RESET = state_ff[0];
endmodule // bstp_port

// [src/bstp_defines.vh]
// Overview of operation
// - mode select sampled on test clock rise
// - low test reset clears port immediately
// - data input shifts in on rise
// - data output changes on falling edge
// - output driven only while shifting
// - parked low clock holds all state
`ifndef BSTP_DEFINES_VH
`define BSTP_DEFINES_VH
`define BSTP_IR_WIDTH 4
`define BSTP_IR_RESET 4'h1
`define BSTP_IR_CAPTURE 4'h1
`define BSTP_OP_BYPASS 4'hF
`define BSTP_OP_IDCODE 4'h1
`define BSTP_ID_WIDTH 32
`define BSTP_SYNC_STAGES 2
`endif

// [src/bstp_sync.v]
`timescale 1ns/10ps
// two flop synchroniser; stage one is read only by stage two
module bstp_sync (
  input wire clk, // sampling clock
  input wire rst, // async reset, high
  input wire d_in, // async level
  output wire q_out // synchronised level
);
  reg s1_ff;
  reg s2_ff;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
    end else begin
      s1_ff <= d_in;
      s2_ff <= s1_ff;
    end
  end
  assign q_out = s2_ff;
endmodule // bstp_sync

// [test/bstp_checker.sv]
`timescale 1ns/10ps
module bstp_checker #(parameter IR_WIDTH = 4) (input wire CLOCK, input wire SYS_RST,
  input wire TCK, input wire TMS, input wire TDI, input wire TRST_N, input wire TDO_O,
  input wire TDO_OE, input wire [IR_WIDTH-1:0] INSTR, input wire TAP_RESET);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST || !TRST_N);
  property p_exit; $fell(TAP_RESET) |-> TCK && !TMS; endproperty
  a_exit: assert property (p_exit) else $error("reset left badly");
  property p_trst; disable iff (SYS_RST) !TRST_N |-> TAP_RESET && !TDO_OE; endproperty
  a_trst: assert property (p_trst) else $error("test reset ignored");
  property p_ir; $changed(INSTR) |-> !TDO_OE; endproperty
  a_ir: assert property (p_ir) else $error("instr moved in shift");
  property p_fall; $changed(TDO_O) || $changed(TDO_OE) |-> $past(!TCK, 2); endproperty
  a_fall: assert property (p_fall) else $error("output off fall");
  property p_oe; $rose(TDO_OE) |-> !TCK && !TAP_RESET; endproperty
  a_oe: assert property (p_oe) else $error("drive outside shift");
  property p_park; !TCK [*8] |-> $stable(INSTR) && $stable(TDO_O) && $stable(TAP_RESET);
  endproperty
  a_park: assert property (p_park) else $error("state drift");
endmodule // bstp_checker
bind bstp_port bstp_checker #(.IR_WIDTH(IR_WIDTH)) chk (.*);

// [test/bstp_ctrl_model.sv]
`timescale 1ns/10ps
module bstp_ctrl_model (input wire clk, input wire tdo, output logic tck = 1'b0,
  output logic tms = 1'b1, output logic tdi = 1'b1, output logic smp = 1'b0, output logic got);
  // clock parks low between steps so the port can hold its state
  task automatic step(input logic m, input logic d);
    @(posedge clk) {tms, tdi} <= {m, d};
    repeat (19) @(posedge clk);
    {got, smp, tck} <= {tdo, 2'b11};
    @(posedge clk) smp <= 1'b0;
    repeat (19) @(posedge clk);
    tck <= 1'b0;
  endtask
endmodule // bstp_ctrl_model

// [test/test_boundary_scan_test_port_pins.sv]
`timescale 1ns/10ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin num_errors++; \
  $display("MISMATCH %0t wrong value", $time); end end
module test_boundary_scan_test_port_pins;
  localparam logic [31:0] ID = 32'hC3A50F01; // arbitrary identity value
  logic clk = 1'b0, rst = 1'b1, trst_n = 1'b0, smp, got, tck, tms, tdi, tdo_o, tdo_oe, tap;
  logic [3:0] instr;
  logic [7:0] r;
  logic q[$];
  int num_errors = 0, comparisons = 0;
  wire tdo = tdo_oe ? tdo_o : 1'bz;
  bstp_port #(.ID_VALUE(ID)) uut (.CLOCK(clk), .SYS_RST(rst), .TCK(tck), .TMS(tms), .TDI(tdi),
    .TRST_N(trst_n), .TDO_O(tdo_o), .TDO_OE(tdo_oe), .INSTR(instr), .TAP_RESET(tap));
  bstp_ctrl_model ctl (.clk(clk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi), .smp(smp),
    .got(got));
  initial forever #2 clk = ~clk;
  always @(posedge clk) if (smp === 1'b1) `CHK(got, q.pop_front())
  task io(input logic m, input logic d, input logic e);
    q.push_back(e);
    ctl.step(m, d);
  endtask
  // mode select walk, lsb first; output is released throughout
  task nav(input logic [7:0] s, input int n);
    for (int i = 0; i < n; i++) io(s[i], 1'b1, 1'bz);
  endtask
  task tally_and_finish;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    void'($urandom(56539));
    r = 8'($urandom);
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    trst_n <= 1'b1;
    repeat (6) @(posedge clk);
    nav(8'h02, 4);
    for (int i = 0; i < 32; i++) io(i == 31, 1'b1, ID[i]);
    nav(8'h01, 2);
    nav(8'h03, 4);
    for (int i = 0; i < 4; i++) io(i == 3, 1'b1, i == 0);
    nav(8'h01, 2);
    `CHK(instr, 4'hF)
    nav(8'h01, 3);
    for (int i = 0; i < 8; i++) io(i == 7, r[i], i > 0 ? r[i-1] : 1'b0);
    nav(8'h01, 2);
    repeat (100) @(posedge clk);
    `CHK(instr, 4'hF)
    // one-cycle test reset pulse with the clock parked must act without a clock edge
    trst_n <= 1'b0;
    @(posedge clk) trst_n <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK({tap, instr}, 5'h11)
    nav(8'h1F, 5);
    repeat (6) @(posedge clk);
    `CHK({tap, instr}, 5'h11)
    tally_and_finish;
  end
  initial begin #50000; num_errors++; tally_and_finish; end
endmodule // test_boundary_scan_test_port_pins
